// ---- rtl/arc_regs.vh ----
// Constants for the automatic reclose sequencer: register offsets,
// field positions, reset values and encodings.
// Assumes a 32-bit APB with byte addresses and word-aligned registers.
`ifndef ARC_REGS_VH
`define ARC_REGS_VH

// Register byte offsets
`define ARC_CTRL_ADDR 8'h00
`define ARC_SRC_CFG_ADDR 8'h04
`define ARC_STATUS_ADDR 8'h08
`define ARC_BLOCK_TIME_ADDR 8'h0C
`define ARC_DEAD_BASE_ADDR 8'h20
`define ARC_DEAD_LAST_ADDR 8'h3C

// Control register fields
`define ARC_CTRL_ENABLE_BIT 0
`define ARC_CTRL_LOCK_CLR_BIT 1
`define ARC_CTRL_SHOTS_LSB 4
`define ARC_CTRL_SHOTS_MSB 7

// Status register fields
`define ARC_STAT_STATE_LSB 0
`define ARC_STAT_STATE_MSB 4
`define ARC_STAT_PROG_BIT 8
`define ARC_STAT_HS_BIT 9
`define ARC_STAT_ATTEMPT_LSB 12
`define ARC_STAT_ATTEMPT_MSB 15

// Reset values and the attempt-count limit
`define ARC_SHOTS_RESET 4'h1
`define ARC_SHOTS_MAX 4'h9
`define ARC_SRC_CFG_RESET 20'h00000
`define ARC_BLOCK_TIME_RESET 16'h0064
`define ARC_DEAD_RESET 16'h0032

// Per-source behaviour codes
`define ARC_SRC_NONE 2'h0
`define ARC_SRC_INIT 2'h1
`define ARC_SRC_BLOCK 2'h2

// Source numbering in the source vector
`define ARC_NUM_SRC 10
`define ARC_SRC_NEG_SEQ 8
`define ARC_SRC_EXT_RELAY 9

`endif

// ---- rtl/auto_reclose_function.v ----
// Automatic reclose sequencer with APB register access.
// Assumes element pickups and trips come from logic on pclk; breaker
// and binary inputs are pins; tick is a same-clock timer strobe.
// Notes on behaviour
// - Programmable reclose attempts, one to nine; retrip recloses or stays open.
// - External relay trip contact on a binary input starts reclosing.
// - Sources: definite, inverse, sensitive ground, negative sequence, binary input.
// - Each source configured to initiate, ignore, or block reclosing.
// - Ground program only when single phase and/or ground elements picked up, or on its input with nothing picked up.
// - Dedicated binary input also starts the ground program.
// - Two or more phases picked up selects the phase program.
// - Non-phase initiators such as negative sequence start the phase program.
// - Dedicated binary input also starts the phase program.
// - Program picked before first attempt, kept for whole sequence.
// - Separate dead time for each of the first four attempts.
// - High-speed trip allowed while two or more attempts remain.
// - High-speed trip suppressed before the final attempt.
// - Initiating trip starts the selected reclose program.
// - Dead time expiry issues close command to the breaker.
// - Attempts five to nine reuse the fourth dead time.
// - Dead timer starts only once the breaker is seen open.
// - Blocking timer starts in the same cycle as the close command.
// - No trip before blocking expiry means success, back to idle.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "arc_regs.vh"
module auto_reclose_function #(
    parameter TW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire tick,
    input wire [2:0] phase_pickup,
    input wire ground_pickup,
    input wire phase_high_set_trip,
    input wire ground_high_set_overcurrent,
    input wire phase_low_set_trip,
    input wire ground_low_set_overcurrent,
    input wire phase_inverse_trip,
    input wire ground_inverse_time_overcurrent,
    input wire sensitive_ground_definite_element,
    input wire sensitive_ground_inverse_element,
    input wire negative_sequence_trip,
    input wire ext_relay_trip_pin,
    input wire ground_program_pin,
    input wire phase_program_pin,
    input wire breaker_open_pin,
    output reg close_cmd,
    output reg final_trip,
    output reg high_speed_enable,
    output reg lockout,
    output reg phase_program
);

// One-hot states
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_WAIT_OPEN = 5'h02;
localparam [4:0] ST_DEAD = 5'h04;
localparam [4:0] ST_BLOCKING = 5'h08;
localparam [4:0] ST_LOCKOUT = 5'h10;

reg [4:0] state;
reg [4:0] next_state;
reg enable;
reg [3:0] shots;
reg [19:0] src_cfg;
reg [TW-1:0] block_time;
reg [3:0] attempt;
reg [TW-1:0] timer;
reg lock_clr;
reg closed_seen;
wire [3:0] pins_sync;
wire ext_trip;
wire gnd_prog_req;
wire ph_prog_req;
wire breaker_open;
wire [`ARC_NUM_SRC-1:0] src_trip;
wire [`ARC_NUM_SRC-1:0] init_hit;
wire [`ARC_NUM_SRC-1:0] block_hit;
wire any_init;
wire any_block;
wire multi_phase;
wire no_pickup;
wire choose_phase;
wire [2:0] seq_addr;
wire [1:0] shot_slot;
wire [TW-1:0] dead_val;
wire [TW-1:0] apb_dead;
wire attempts_left;
wire access;
wire wr;
wire rd;
wire dead_sel;
wire mapped;
wire [4:0] status_state;
wire hs_next;

// Binary inputs cross into pclk before use
pin_sync #(
    .WIDTH(4)
) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in({breaker_open_pin, phase_program_pin, ground_program_pin, ext_relay_trip_pin}),
    .pin_out(pins_sync)
);

assign ext_trip = pins_sync[0];
assign gnd_prog_req = pins_sync[1];
assign ph_prog_req = pins_sync[2];
assign breaker_open = pins_sync[3];

// Source vector in configuration order
assign src_trip = {ext_trip,
                   negative_sequence_trip,
                   sensitive_ground_inverse_element,
                   sensitive_ground_definite_element,
                   ground_inverse_time_overcurrent,
                   phase_inverse_trip,
                   ground_low_set_overcurrent,
                   phase_low_set_trip,
                   ground_high_set_overcurrent,
                   phase_high_set_trip};

// Per-source decode of the two-bit behaviour code
genvar s;
generate
    for (s = 0; s < `ARC_NUM_SRC; s = s + 1) begin : g_src
        assign init_hit[s] = src_trip[s] && (src_cfg[2*s+1:2*s] == `ARC_SRC_INIT);
        assign block_hit[s] = src_trip[s] && (src_cfg[2*s+1:2*s] == `ARC_SRC_BLOCK);
    end
endgenerate

assign any_init = |init_hit;
assign any_block = |block_hit;

// Program choice from pickups and program requests
assign multi_phase = (phase_pickup[0] & phase_pickup[1]) |
                     (phase_pickup[0] & phase_pickup[2]) |
                     (phase_pickup[1] & phase_pickup[2]);
// No element picked up at all, as on a bare external relay trip
assign no_pickup = ~(|phase_pickup) & ~ground_pickup;
// Phase program on multi-phase, a non-phase initiator or its input, and in
// every case that is not single phase and/or ground; the ground input
// claims that last case for the ground program
assign choose_phase = multi_phase | init_hit[`ARC_SRC_NEG_SEQ] | ph_prog_req |
                      (no_pickup & ~gnd_prog_req);

// Dead-time slot: attempts past the fourth reuse the fourth slot
assign shot_slot = (attempt > 4'h3) ? 2'h3 : attempt[1:0];
assign seq_addr = {~phase_program, shot_slot};
assign attempts_left = (attempt < shots);

// APB decode
assign access = psel && penable;
assign wr = access && pwrite;
assign rd = access && !pwrite;
assign dead_sel = (paddr >= `ARC_DEAD_BASE_ADDR) && (paddr <= `ARC_DEAD_LAST_ADDR) &&
                  (paddr[1:0] == 2'h0);
assign mapped = dead_sel || (paddr == `ARC_CTRL_ADDR) || (paddr == `ARC_SRC_CFG_ADDR) ||
                (paddr == `ARC_STATUS_ADDR) || (paddr == `ARC_BLOCK_TIME_ADDR);
assign pready = 1'b1;
assign pslverr = access && !mapped;

// Dead-time settings; port a serves the bus, port b the sequencer
dead_time_ram #(
    .WIDTH(TW),
    .DEPTH(8),
    .AW(3),
    .INIT(`ARC_DEAD_RESET)
) u_dead_time_ram (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .wr_en(wr && dead_sel),
    .wr_addr(paddr[4:2]),
    .wr_data(pwdata[TW-1:0]),
    .rd_addr_a(paddr[4:2]),
    .rd_data_a(apb_dead),
    .rd_addr_b(seq_addr),
    .rd_data_b(dead_val)
);

// Software registers
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        enable <= 1'b0;
        shots <= `ARC_SHOTS_RESET;
        src_cfg <= `ARC_SRC_CFG_RESET;
        block_time <= `ARC_BLOCK_TIME_RESET;
        lock_clr <= 1'b0;
    end else if (clk_en) begin
        lock_clr <= 1'b0;
        if (wr && (paddr == `ARC_CTRL_ADDR)) begin
            enable <= pwdata[`ARC_CTRL_ENABLE_BIT];
            lock_clr <= pwdata[`ARC_CTRL_LOCK_CLR_BIT];
            if (pwdata[`ARC_CTRL_SHOTS_MSB:`ARC_CTRL_SHOTS_LSB] > `ARC_SHOTS_MAX) begin
                shots <= `ARC_SHOTS_MAX;
            end else if (pwdata[`ARC_CTRL_SHOTS_MSB:`ARC_CTRL_SHOTS_LSB] == 4'h0) begin
                shots <= 4'h1;
            end else begin
                shots <= pwdata[`ARC_CTRL_SHOTS_MSB:`ARC_CTRL_SHOTS_LSB];
            end
        end
        if (wr && (paddr == `ARC_SRC_CFG_ADDR)) begin
            src_cfg <= pwdata[19:0];
        end
        if (wr && (paddr == `ARC_BLOCK_TIME_ADDR)) begin
            block_time <= pwdata[TW-1:0];
        end
    end
end

// Read data mux; the dead-time port was addressed in the setup cycle
assign status_state = state;
assign prdata = !rd ? 32'h00000000 :
                (paddr == `ARC_CTRL_ADDR) ? {24'h000000, shots, 3'h0, enable} :
                (paddr == `ARC_SRC_CFG_ADDR) ? {12'h000, src_cfg} :
                (paddr == `ARC_STATUS_ADDR) ? {16'h0000, attempt, 2'h0, high_speed_enable,
                                               phase_program, 3'h0, status_state} :
                (paddr == `ARC_BLOCK_TIME_ADDR) ? {{(32-TW){1'b0}}, block_time} :
                dead_sel ? {{(32-TW){1'b0}}, apb_dead} : 32'h00000000;

// Next-state logic
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: begin
            if (enable && any_init && !any_block) begin
                next_state = ST_WAIT_OPEN;
            end
        end
        ST_WAIT_OPEN: begin
            if (!enable || any_block) begin
                next_state = ST_LOCKOUT;
            end else if (breaker_open && closed_seen) begin
                next_state = ST_DEAD;
            end
        end
        ST_DEAD: begin
            if (!enable || any_block) begin
                next_state = ST_LOCKOUT;
            end else if (tick && (timer >= dead_val)) begin
                next_state = ST_BLOCKING;
            end
        end
        ST_BLOCKING: begin
            if (any_block) begin
                next_state = ST_LOCKOUT;
            end else if (any_init) begin
                if (attempts_left) begin
                    next_state = ST_WAIT_OPEN;
                end else begin
                    next_state = ST_LOCKOUT;
                end
            end else if (tick && (timer >= block_time)) begin
                next_state = ST_IDLE;
            end
        end
        ST_LOCKOUT: begin
            if (lock_clr) begin
                next_state = ST_IDLE;
            end
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end

// State, timer, attempt count, program latch and command pulses
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state <= ST_IDLE;
        timer <= {TW{1'b0}};
        attempt <= 4'h0;
        phase_program <= 1'b0;
        close_cmd <= 1'b0;
        final_trip <= 1'b0;
        lockout <= 1'b0;
    end else if (clk_en) begin
        state <= next_state;
        close_cmd <= 1'b0;
        final_trip <= 1'b0;
        if (state == ST_IDLE && next_state == ST_WAIT_OPEN) begin
            phase_program <= choose_phase;
            attempt <= 4'h0;
        end
        if (next_state == ST_DEAD && state != ST_DEAD) begin
            timer <= {TW{1'b0}};
        end else if (next_state == ST_BLOCKING && state == ST_DEAD) begin
            timer <= {TW{1'b0}};
            close_cmd <= 1'b1;
            attempt <= attempt + 4'h1;
        end else if (tick && (state == ST_DEAD || state == ST_BLOCKING)) begin
            if (timer != {TW{1'b1}}) begin
                timer <= timer + {{(TW-1){1'b0}}, 1'b1};
            end
        end
        if (next_state == ST_LOCKOUT && state != ST_LOCKOUT) begin
            final_trip <= 1'b1;
            lockout <= 1'b1;
        end
        if (next_state == ST_IDLE && state != ST_IDLE) begin
            attempt <= 4'h0;
            lockout <= 1'b0;
        end
    end
end

// Breaker reported closed since the last close command; keeps a stale
// open indication from starting the next dead time early
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        closed_seen <= 1'b0;
    end else if (clk_en) begin
        if (next_state == ST_BLOCKING && state == ST_DEAD) begin
            closed_seen <= 1'b0;
        end else if (!breaker_open) begin
            closed_seen <= 1'b1;
        end
    end
end

// Fast tripping drops in the same cycle as lockout is entered, so the two
// are never seen high together
assign hs_next = enable && (next_state != ST_LOCKOUT) && (shots >= 4'h2) &&
                 ((attempt + 4'h1) < shots);

// High-speed trip allowed only while this is not the final attempt
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        high_speed_enable <= 1'b0;
    end else if (clk_en) begin
        high_speed_enable <= hs_next;
    end
end

endmodule

// ---- rtl/dead_time_ram.v ----
// Small store for the dead-time settings, one write port, two read ports.
// Assumes same-clock access; read data come out of registers one cycle later.
`timescale 1ns/1ps
module dead_time_ram #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3,
    parameter [15:0] INIT = 16'h0032
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr_a,
    output reg [WIDTH-1:0] rd_data_a,
    input wire [AW-1:0] rd_addr_b,
    output reg [WIDTH-1:0] rd_data_b
);

reg [WIDTH-1:0] mem [0:DEPTH-1];

// One write path per entry
genvar i;
generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem[i] <= INIT[WIDTH-1:0];
            end else if (clk_en && wr_en && (wr_addr == i)) begin
                mem[i] <= wr_data;
            end
        end
    end
endgenerate

// Registered read ports
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rd_data_a <= {WIDTH{1'b0}};
        rd_data_b <= {WIDTH{1'b0}};
    end else if (clk_en) begin
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end
end

endmodule

// ---- rtl/pin_sync.v ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to pclk; output is a level.
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 4
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_out
);

reg [WIDTH-1:0] stage1;

// First stage feeds only the second
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stage1 <= {WIDTH{1'b0}};
        pin_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
        stage1 <= pin_in;
        pin_out <= stage1;
    end
end

endmodule

// ---- testbench/auto_reclose_function_properties.sv ----
// Concurrent checks on the reclose sequencer outputs.
// Assumes binding to auto_reclose_function; one clock, pclk, async reset presetn.
`timescale 1ns/1ps
module arc_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire breaker_open_pin,
    input wire close_cmd,
    input wire final_trip,
    input wire high_speed_enable,
    input wire lockout,
    input wire phase_program
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Close is a single pulse and does not repeat within the next four cycles
    property p_close_pulse; close_cmd |=> !close_cmd [*4]; endproperty
    a_close_pulse: assert property (p_close_pulse) else $error("close repeated");
    // Close only after the breaker has been seen open
    property p_close_open; close_cmd |-> $past(breaker_open_pin, 3); endproperty
    a_close_open: assert property (p_close_open) else $error("close while closed");
    // No close while locked out
    property p_lock_noclose; lockout |-> !close_cmd; endproperty
    a_lock_noclose: assert property (p_lock_noclose) else $error("close in lockout");
    // Entry to lockout comes with the final trip
    property p_lock_trip; $rose(lockout) |-> final_trip; endproperty
    a_lock_trip: assert property (p_lock_trip) else $error("lockout without trip");
    // Final trip is a one-cycle pulse
    property p_trip_pulse; final_trip |=> !final_trip; endproperty
    a_trip_pulse: assert property (p_trip_pulse) else $error("final trip too long");
    // Clear written at the last edge; lockout falls one cycle after the write
    reg clr_seen;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            clr_seen <= 1'b0;
        else
            clr_seen <= psel && penable && pwrite && paddr == 8'h00 && pwdata[1];
    end
    // Lockout holds until a clear is written
    property p_lock_hold;
        lockout && !clr_seen && !(psel && penable && pwrite && paddr == 8'h00 && pwdata[1])
            |=> lockout;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lockout dropped");
    // Fast tripping is off in lockout
    property p_hs_lock; high_speed_enable |-> !lockout; endproperty
    a_hs_lock: assert property (p_hs_lock) else $error("fast trip in lockout");
    // Program does not change at a reclose
    property p_prog_keep; close_cmd |-> $stable(phase_program); endproperty
    a_prog_keep: assert property (p_prog_keep) else $error("program changed");
endmodule

bind auto_reclose_function arc_checker arc_checker_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .breaker_open_pin(breaker_open_pin),
    .close_cmd(close_cmd),
    .final_trip(final_trip),
    .high_speed_enable(high_speed_enable),
    .lockout(lockout),
    .phase_program(phase_program)
);

// ---- testbench/breaker_model.sv ----
// Feeder breaker model: opens after a held trip, closes after a close pulse.
// Assumes trip_req is any trip contact level; DLY sets how slow it moves.
`timescale 1ns/1ps
module breaker_model #(
    parameter DLY = 2
) (
    input wire pclk,
    input wire presetn,
    input wire trip_req,
    input wire close_cmd,
    output reg breaker_open_pin
);
    reg [3:0] cnt;
    reg closing;
    // Move the contacts once the request has lasted DLY+1 cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            breaker_open_pin <= 1'b0;
            cnt <= 4'h0;
            closing <= 1'b0;
        end else begin
            if (close_cmd)
                closing <= 1'b1;
            if (breaker_open_pin ? (closing || close_cmd) : trip_req) begin
                cnt <= cnt + 4'h1;
                if (cnt >= DLY) begin
                    breaker_open_pin <= !breaker_open_pin;
                    cnt <= 4'h0;
                    closing <= 1'b0;
                end
            end else
                cnt <= 4'h0;
        end
    end
endmodule

// ---- testbench/test_auto_reclose_function.sv ----
// Self-checking bench for the reclose sequencer over APB.
// Assumes a 200 MHz pclk, tick every fourth cycle and the breaker model.
`timescale 1ns/1ps
module test_auto_reclose_function;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tick = 0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h00000000;
    reg [8:0] trips = 9'h000;
    reg [2:0] phase_pickup = 3'h0;
    reg ground_pickup = 0, ext_pin = 0, gprog_pin = 0, pprog_pin = 0, clk_en = 1;
    reg [3:0] tc = 4'h0;
    reg [31:0] rd;
    reg err;
    wire [31:0] prdata;
    wire pready, pslverr, breaker_open_pin, close_cmd, final_trip, hs, lockout, phase_program;
    integer err_count = 0, comparisons = 0, i, n;
    auto_reclose_function auto_reclose_function_inst (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick(tick),
        .phase_pickup(phase_pickup), .ground_pickup(ground_pickup),
        .phase_high_set_trip(trips[0]), .ground_high_set_overcurrent(trips[1]),
        .phase_low_set_trip(trips[2]), .ground_low_set_overcurrent(trips[3]),
        .phase_inverse_trip(trips[4]), .ground_inverse_time_overcurrent(trips[5]),
        .sensitive_ground_definite_element(trips[6]), .sensitive_ground_inverse_element(trips[7]),
        .negative_sequence_trip(trips[8]), .ext_relay_trip_pin(ext_pin),
        .ground_program_pin(gprog_pin), .phase_program_pin(pprog_pin),
        .breaker_open_pin(breaker_open_pin), .close_cmd(close_cmd), .final_trip(final_trip),
        .high_speed_enable(hs), .lockout(lockout), .phase_program(phase_program));
    breaker_model breaker_model_inst (.pclk(pclk), .presetn(presetn),
        .trip_req(|trips || ext_pin), .close_cmd(close_cmd), .breaker_open_pin(breaker_open_pin));
    // Clock and a timer tick one cycle in four
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        tc <= tc + 4'h1;
        tick <= (tc[1:0] == 2'h3);
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // One APB transfer; read data and error taken at the pready edge
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Trip until the breaker opens, then count ticks up to the close pulse
    task shot(input [9:0] t, input [31:0] dead);
        integer k;
        begin
            trips <= t[8:0];
            ext_pin <= t[9];
            n = 0;
            while (breaker_open_pin !== 1'b1 && n < 100) begin
                @(posedge pclk);
                n = n + 1;
            end
            trips <= 9'h000;
            ext_pin <= 1'b0;
            k = 0;
            n = 0;
            while (close_cmd !== 1'b1 && n < 2000) begin
                @(posedge pclk);
                n = n + 1;
                if (tick) k = k + 1;
            end
            check(k >= dead + 1 && k <= dead + 2, 1);
            repeat (6) @(posedge pclk);
        end
    endtask
    task t_regs;
        begin
            apb(0, 8'h00, 0); check(rd, 32'h10);
            apb(0, 8'h0C, 0); check(rd, 32'h64);
            apb(0, 8'h3C, 0); check(rd, 32'h32);
            apb(0, 8'h40, 0); check(err, 1);
            apb(1, 8'h00, 32'hF0); apb(0, 8'h00, 0); check(rd, 32'h90);
            for (i = 0; i < 8; i = i + 1) apb(1, 8'h20 + 4 * i, i + 1);
            apb(1, 8'h0C, 20);
            clk_en <= 1'b0;
            apb(1, 8'h0C, 32'h63);
            clk_en <= 1'b1;
            apb(0, 8'h0C, 0); check(rd, 32'h14);
            apb(1, 8'h04, 32'h50025);
            apb(1, 8'h00, 32'h21);
        end
    endtask
    // One single-shot sequence with a given fault picture and program
    task t_prog(input [2:0] pick, input [9:0] t, input gp, input pp, input prog, input [31:0] d);
        begin
            phase_pickup <= pick;
            ground_pickup <= pick[0] & !pick[1];
            gprog_pin <= gp;
            pprog_pin <= pp;
            repeat (3) @(posedge pclk);
            shot(t, d);
            check(phase_program, prog);
            repeat (100) @(posedge pclk);
            apb(0, 8'h08, 0); check(rd & 32'hF01F, 32'h1);
            check(hs, 1);
            gprog_pin <= 1'b0;
            pprog_pin <= 1'b0;
        end
    endtask
    // Blocking and ignored sources keep the sequencer idle
    task t_block;
        begin
            trips <= 9'h005;
            @(posedge pclk);
            trips <= 9'h008;
            @(posedge pclk);
            trips <= 9'h000;
            repeat (4) @(posedge pclk);
            apb(0, 8'h08, 0); check(rd & 32'h1F, 32'h1);
        end
    endtask
    // Six attempts, then a retrip in blocking locks out
    task t_multi;
        begin
            apb(1, 8'h00, 32'h61);
            phase_pickup <= 3'b011;
            for (i = 0; i < 6; i = i + 1) begin
                shot(10'h001, (i < 3 ? i : 3) + 1);
                phase_pickup <= 3'b001;
                check(phase_program, 1);
                check(hs, i < 4);
            end
            trips <= 9'h001;
            n = 0;
            while (final_trip !== 1'b1 && n < 200) begin
                @(posedge pclk);
                n = n + 1;
            end
            check(n < 200, 1);
            trips <= 9'h000;
            apb(0, 8'h08, 0); check(rd & 32'h1F, 32'h10);
            check(lockout, 1);
            apb(1, 8'h00, 32'h63);
            apb(0, 8'h08, 0); check(rd & 32'hF01F, 32'h1);
            check(lockout, 0);
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Watchdog against a hung sequence
    initial begin
        repeat (40000) @(posedge pclk);
        err_count = err_count + 1;
        conclude;
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_prog(3'b011, 10'h001, 0, 0, 1, 1);
        t_prog(3'b001, 10'h002, 0, 0, 0, 5);
        t_prog(3'b000, 10'h100, 0, 0, 1, 1);
        t_prog(3'b000, 10'h200, 1, 0, 0, 5);
        t_prog(3'b000, 10'h200, 0, 0, 1, 1);
        t_prog(3'b001, 10'h001, 0, 1, 1, 1);
        t_block;
        t_multi;
        conclude;
    end
endmodule
